// ### mrt_host.sv
/*
 host controller model: drives position clear, homing done and the
 serial alarm reset. assumes the bench calls its tasks.
*/
`timescale 1ns/1ps
module mrt_host (
	input wire i_mclk,
	output logic o_pos_clear = 1'b0,
	output logic o_home_done = 1'b0,
	output logic o_serial_reset = 1'b0
);
	// position clear driven active, then inactive
	task pulse_clear;
		@(posedge i_mclk) o_pos_clear <= 1'b1;
		repeat (3) @(posedge i_mclk);
		o_pos_clear <= 1'b0;
	endtask
	// homing done pulsed high for one clock; alarm state not waited for
	task finish_home;
		@(posedge i_mclk) o_home_done <= 1'b1;
		@(posedge i_mclk) o_home_done <= 1'b0;
	endtask
	// dedicated reset command over the serial link
	task serial_reset;
		@(posedge i_mclk) o_serial_reset <= 1'b1;
		@(posedge i_mclk) o_serial_reset <= 1'b0;
	endtask
endmodule

// ### mrt_regs.vh
/*
 register offsets, field positions, reset values and timing counts
 for the motor response tuning block; included by the design file
*/
`ifndef MRT_REGS_VH
`define MRT_REGS_VH
// byte offsets on the register bus
`define MRT_OFS_CTRL 8'h00
`define MRT_OFS_SPD_FILT 8'h04
`define MRT_OFS_MAVG 8'h08
`define MRT_OFS_GAIN1 8'h0C
`define MRT_OFS_GAIN2 8'h10
`define MRT_OFS_POS_GAIN 8'h14
`define MRT_OFS_SPD_GAIN 8'h18
`define MRT_OFS_INTEG 8'h1C
`define MRT_OFS_STATUS 8'h20
`define MRT_OFS_IRQ_STAT 8'h24
`define MRT_OFS_IRQ_MASK 8'h28
`define MRT_OFS_CMD 8'h2C
// control field positions
`define MRT_CTRL_FSEL 0
`define MRT_CTRL_MODE 1
`define MRT_CTRL_ABS 2
// status field positions
`define MRT_ST_ALARM 0
`define MRT_ST_VALID 1
`define MRT_ST_ACCEL 2
`define MRT_ST_CURMODE 3
// event bits
`define MRT_EV_ALARM_SET 0
`define MRT_EV_ALARM_CLR 1
// command bit
`define MRT_CMD_ALM_RST 0
// reset values
`define MRT_RST_FSEL 1'b0
`define MRT_RST_MODE 1'b0
`define MRT_RST_ABS 1'b0
`define MRT_RST_SPD_FILT 8'h01
`define MRT_RST_MAVG 8'h01
`define MRT_RST_GAIN 9'h02D
`define MRT_RST_POS_GAIN 6'h01
`define MRT_RST_SPD_GAIN 8'h0A
`define MRT_RST_INTEG 11'h3E8
// setting limits
`define MRT_MAX_FILT 8'hC8
`define MRT_MAX_GAIN 9'h1F4
`define MRT_MAX_POS_GAIN 6'h32
`define MRT_MIN_SPD_GAIN 8'h0A
`define MRT_MAX_SPD_GAIN 8'hC8
`define MRT_MIN_INTEG 11'h064
`define MRT_MAX_INTEG 11'h7D0
// filter sample period
`define MRT_CLK_HZ 50000000
`define MRT_TICK_US 1000
`define MRT_TICK_CYC (`MRT_CLK_HZ / 1000000 * `MRT_TICK_US)
`endif

// ### mrt_top.v
/*
 motor response tuning and absolute position backup stage: command
 smoothing filters, damping gain choice, loop parameters for current
 control mode, backup alarm handling, AHB-Lite register slave.
 assumes one 50 MHz clock, inputs synchronous to it, a single master
 doing single word transfers, and battery-held flags presented at
 power-up on the retained inputs.
*/
// Overview of operation
// - filter select: 0 speed filter, 1 averaging
// - speed filter time only used when selected
// - speed filter time 0..200 ms, reset 1
// - speed filter time zero bypasses smoothing
// - moving average time 1..200 ms, reset 1
// - gain 1 damps constant speed vibration
// - gain 2 damps accel and decel vibration
// - control mode: 0 normal, 1 current control
// - loop parameters applied only in current mode
// - position loop gain range 1..50
// - speed loop gain range 10..200
// - integral time 100..2000, reset 1000
// - backup enable bit, reset disabled
// - first power-up after enabling raises alarm
// - position clear falling edge clears alarm
// - serial reset command clears alarm
// - valid retained position restored at power-up
`timescale 1ns/1ps
`include "mrt_regs.vh"
module mrt_top #(
	parameter CMD_W = 16,
	parameter TICK_CYC = `MRT_TICK_CYC,
	parameter AVG_DEPTH = 256
) (
	input wire i_mclk,
	input wire i_reset_n,
	input wire i_hsel,
	input wire [7:0] i_haddr,
	input wire [1:0] i_htrans,
	input wire i_hwrite,
	input wire [2:0] i_hsize,
	input wire [31:0] i_hwdata,
	input wire i_hready,
	output reg [31:0] o_hrdata,
	output wire o_hreadyout,
	output wire o_hresp,
	input wire signed [CMD_W-1:0] i_cmd_speed,
	input wire i_pos_clear_input,
	input wire i_serial_alarm_reset,
	input wire i_home_done,
	input wire i_nv_abs_enable,
	input wire i_nv_pos_valid,
	output reg signed [CMD_W-1:0] o_speed_out,
	output reg [8:0] o_damp_gain,
	output reg o_current_mode,
	output reg [5:0] o_pos_gain,
	output reg [7:0] o_spd_gain,
	output reg [10:0] o_integ_time,
	output reg o_abs_enable,
	output reg o_abs_alarm,
	output reg o_pos_valid,
	output reg o_pos_restore,
	output wire o_irq
);
	localparam AW = $clog2(AVG_DEPTH);
	localparam SW = CMD_W + 8;

	// bus slave: always ready, always okay
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;

	// software registers
	reg fsel;
	reg cmode;
	reg [7:0] spd_filt;
	reg [7:0] mavg_t;
	reg [8:0] gain1;
	reg [8:0] gain2;
	reg [5:0] pos_gain;
	reg [7:0] spd_gain;
	reg [10:0] integ;
	reg [1:0] irq_stat;
	reg [1:0] irq_mask;
	reg accel;

	// address phase capture for writes
	reg wr_pend;
	reg [7:0] wr_addr;
	wire acc = i_hsel & i_hready & i_htrans[1];
	wire wr_go = wr_pend;
	wire [31:0] wd = i_hwdata;

	// alarm event strobes
	reg alarm_set_ev;
	reg alarm_clr_ev;
	wire cmd_rst = wr_go & (wr_addr == `MRT_OFS_CMD) & wd[`MRT_CMD_ALM_RST];

	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= acc & i_hwrite;
			if (acc)
				wr_addr <= i_haddr;
		end
	end

	// write side with range limiting; out of range writes clamp
	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			fsel <= `MRT_RST_FSEL;
			cmode <= `MRT_RST_MODE;
			o_abs_enable <= `MRT_RST_ABS;
			spd_filt <= `MRT_RST_SPD_FILT;
			mavg_t <= `MRT_RST_MAVG;
			gain1 <= `MRT_RST_GAIN;
			gain2 <= `MRT_RST_GAIN;
			pos_gain <= `MRT_RST_POS_GAIN;
			spd_gain <= `MRT_RST_SPD_GAIN;
			integ <= `MRT_RST_INTEG;
			irq_mask <= 2'b00;
		end else if (wr_go) begin
			case (wr_addr)
			`MRT_OFS_CTRL: begin
				fsel <= wd[`MRT_CTRL_FSEL];
				cmode <= wd[`MRT_CTRL_MODE];
				o_abs_enable <= wd[`MRT_CTRL_ABS];
			end
			`MRT_OFS_SPD_FILT: begin
				spd_filt <= (wd > `MRT_MAX_FILT) ? `MRT_MAX_FILT : wd[7:0];
			end
			`MRT_OFS_MAVG: begin
				if (wd == 32'h0000_0000)
					mavg_t <= 8'h01;
				else
					mavg_t <= (wd > `MRT_MAX_FILT) ? `MRT_MAX_FILT : wd[7:0];
			end
			`MRT_OFS_GAIN1: begin
				gain1 <= (wd > `MRT_MAX_GAIN) ? `MRT_MAX_GAIN : wd[8:0];
			end
			`MRT_OFS_GAIN2: begin
				gain2 <= (wd > `MRT_MAX_GAIN) ? `MRT_MAX_GAIN : wd[8:0];
			end
			`MRT_OFS_POS_GAIN: begin
				if (wd == 32'h0000_0000)
					pos_gain <= 6'h01;
				else
					pos_gain <= (wd > `MRT_MAX_POS_GAIN) ? `MRT_MAX_POS_GAIN : wd[5:0];
			end
			`MRT_OFS_SPD_GAIN: begin
				if (wd < `MRT_MIN_SPD_GAIN)
					spd_gain <= `MRT_MIN_SPD_GAIN;
				else
					spd_gain <= (wd > `MRT_MAX_SPD_GAIN) ? `MRT_MAX_SPD_GAIN : wd[7:0];
			end
			`MRT_OFS_INTEG: begin
				if (wd < `MRT_MIN_INTEG)
					integ <= `MRT_MIN_INTEG;
				else
					integ <= (wd > `MRT_MAX_INTEG) ? `MRT_MAX_INTEG : wd[10:0];
			end
			`MRT_OFS_IRQ_MASK: begin
				irq_mask <= wd[1:0];
			end
			default: begin
			end
			endcase
		end
	end

	// read data registered in the address phase, zero wait states
	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_hrdata <= 32'h0000_0000;
		end else if (acc & ~i_hwrite) begin
			case (i_haddr)
			`MRT_OFS_CTRL: o_hrdata <= {29'h0, o_abs_enable, cmode, fsel};
			`MRT_OFS_SPD_FILT: o_hrdata <= {24'h0, spd_filt};
			`MRT_OFS_MAVG: o_hrdata <= {24'h0, mavg_t};
			`MRT_OFS_GAIN1: o_hrdata <= {23'h0, gain1};
			`MRT_OFS_GAIN2: o_hrdata <= {23'h0, gain2};
			`MRT_OFS_POS_GAIN: o_hrdata <= {26'h0, pos_gain};
			`MRT_OFS_SPD_GAIN: o_hrdata <= {24'h0, spd_gain};
			`MRT_OFS_INTEG: o_hrdata <= {21'h0, integ};
			`MRT_OFS_STATUS: o_hrdata <= {28'h0, cmode, accel, o_pos_valid, o_abs_alarm};
			`MRT_OFS_IRQ_STAT: o_hrdata <= {30'h0, irq_stat};
			`MRT_OFS_IRQ_MASK: o_hrdata <= {30'h0, irq_mask};
			default: o_hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// sticky events, write one to clear; a new event beats the clear
	wire [1:0] ev = {alarm_clr_ev, alarm_set_ev};
	wire [1:0] w1c = (wr_go && wr_addr == `MRT_OFS_IRQ_STAT) ? wd[1:0] : 2'b00;
	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n)
			irq_stat <= 2'b00;
		else
			irq_stat <= (irq_stat & ~w1c) | ev;
	end
	assign o_irq = |(irq_stat & irq_mask);

	// power-up sequencing: retained flags caught one edge after release
	localparam PU_WAIT = 3'b001;
	localparam PU_EVAL = 3'b010;
	localparam PU_RUN = 3'b100;
	reg [2:0] pu_state;
	reg nv_en;
	reg nv_valid;
	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pu_state <= PU_WAIT;
			nv_en <= 1'b0;
			nv_valid <= 1'b0;
		end else begin
			case (pu_state)
			PU_WAIT: begin
				nv_en <= i_nv_abs_enable;
				nv_valid <= i_nv_pos_valid;
				pu_state <= PU_EVAL;
			end
			PU_EVAL: pu_state <= PU_RUN;
			PU_RUN: pu_state <= PU_RUN;
			default: pu_state <= PU_WAIT;
			endcase
		end
	end
	wire pu_eval = pu_state[1];

	// position clear edge detect
	reg pclr_d;
	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n)
			pclr_d <= 1'b0;
		else
			pclr_d <= i_pos_clear_input;
	end
	wire pclr_fall = pclr_d & ~i_pos_clear_input;

	// alarm raise at power-up, clear by edge or reset command
	wire raise = pu_eval & nv_en & ~nv_valid;
	wire clr = pclr_fall | i_serial_alarm_reset | cmd_rst;
	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_abs_alarm <= 1'b0;
			alarm_set_ev <= 1'b0;
			alarm_clr_ev <= 1'b0;
		end else begin
			alarm_set_ev <= raise;
			alarm_clr_ev <= clr & o_abs_alarm & ~raise;
			if (raise)
				o_abs_alarm <= 1'b1;
			else if (clr)
				o_abs_alarm <= 1'b0;
		end
	end

	// retained position validity and restore pulse
	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_pos_valid <= 1'b0;
			o_pos_restore <= 1'b0;
		end else begin
			o_pos_restore <= pu_eval & nv_en & nv_valid;
			if (raise | o_abs_alarm)
				o_pos_valid <= 1'b0;
			else if (pu_eval & nv_en & nv_valid)
				o_pos_valid <= 1'b1;
			else if (i_home_done)
				o_pos_valid <= 1'b1;
		end
	end

	// 1 ms sample tick
	reg [31:0] tick_cnt;
	wire tick = (tick_cnt == TICK_CYC - 1);
	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n)
			tick_cnt <= 32'h0000_0000;
		else if (tick)
			tick_cnt <= 32'h0000_0000;
		else
			tick_cnt <= tick_cnt + 32'h0000_0001;
	end

	// speed filter: first order lag, step of error over time setting
	// divisor is the setting plus one, so a zero setting never divides by zero
	reg signed [SW-1:0] lag;
	wire signed [SW-1:0] cmd_x = {{(SW-CMD_W){i_cmd_speed[CMD_W-1]}}, i_cmd_speed};
	wire signed [SW-1:0] lag_err = cmd_x - lag;
	wire signed [SW-1:0] lag_div = {{(SW-8){1'b0}}, spd_filt} + {{(SW-1){1'b0}}, 1'b1};
	wire signed [SW-1:0] lag_step = lag_err / lag_div;
	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n)
			lag <= {SW{1'b0}};
		else if (tick)
			lag <= (lag_step == 0) ? cmd_x : lag + lag_step;
	end

	// a new averaging time restarts the history one cycle after the write
	reg mavg_load;
	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n)
			mavg_load <= 1'b0;
		else
			mavg_load <= wr_go & (wr_addr == `MRT_OFS_MAVG);
	end

	// moving average over the last mavg_t samples; the running sum is only
	// true for a fixed length, so a new length reloads it from the output
	reg signed [CMD_W-1:0] hist [0:AVG_DEPTH-1];
	reg [AW-1:0] wp;
	reg signed [SW-1:0] msum;
	wire [AW-1:0] rp = wp - mavg_t[AW-1:0];
	wire signed [CMD_W-1:0] old_w = hist[rp];
	wire signed [SW-1:0] old = {{(SW-CMD_W){old_w[CMD_W-1]}}, old_w};
	wire signed [SW-1:0] out_x = {{(SW-CMD_W){o_speed_out[CMD_W-1]}}, o_speed_out};
	wire signed [SW-1:0] mavg_len = {{(SW-8){1'b0}}, mavg_t};
	integer k;
	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wp <= {AW{1'b0}};
			msum <= {SW{1'b0}};
			for (k = 0; k < AVG_DEPTH; k = k + 1)
				hist[k] <= {CMD_W{1'b0}};
		end else if (mavg_load) begin
			for (k = 0; k < AVG_DEPTH; k = k + 1)
				hist[k] <= o_speed_out;
			msum <= out_x * mavg_len;
		end else if (tick) begin
			hist[wp] <= i_cmd_speed;
			wp <= wp + 1'b1;
			msum <= msum + cmd_x - old;
		end
	end
	wire signed [SW-1:0] mavg = msum / mavg_len;

	// output select and phase detection
	reg signed [CMD_W-1:0] next_speed;
	always @* begin
		if (fsel & mavg_load)
			next_speed = o_speed_out;
		else if (fsel)
			next_speed = mavg[CMD_W-1:0];
		else if (spd_filt == 8'h00)
			next_speed = i_cmd_speed;
		else
			next_speed = lag[CMD_W-1:0];
	end
	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_speed_out <= {CMD_W{1'b0}};
			accel <= 1'b0;
			o_damp_gain <= `MRT_RST_GAIN;
		end else begin
			o_speed_out <= next_speed;
			accel <= (next_speed != i_cmd_speed);
			o_damp_gain <= accel ? gain2 : gain1;
		end
	end

	// loop parameters only reach the loop in current control mode
	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_current_mode <= 1'b0;
			o_pos_gain <= 6'h00;
			o_spd_gain <= 8'h00;
			o_integ_time <= 11'h000;
		end else begin
			o_current_mode <= cmode;
			o_pos_gain <= cmode ? pos_gain : 6'h00;
			o_spd_gain <= cmode ? spd_gain : 8'h00;
			o_integ_time <= cmode ? integ : 11'h000;
		end
	end
endmodule

// ### mrt_top_bench.sv
/*
 self-checking bench for the motor response tuning block: AHB-Lite
 register tasks, alarm and filter scenarios. assumes a 50 MHz clock.
*/
`timescale 1ns/1ps
module mrt_top_bench;
	logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, nv_en = 1'b0, nv_ok = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0000_0000, rd;
	logic signed [15:0] cmd = 16'sh0000;
	wire [31:0] hrdata;
	wire hready, pclr, home, sreset, alarm, valid, restore, cmode, irq;
	wire [5:0] pgain;
	wire [8:0] damp;
	wire [7:0] sgain;
	wire [10:0] itime;
	wire abs_en;
	wire signed [15:0] spd;
	int err_count = 0, check_count = 0, cyc = 0, rcnt = 0, i;
	logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C};
	logic [31:0] rv[6] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0001, 32'h0000_002D, 32'h0000_002D, 32'h0000_03E8};
	logic [7:0] ca[10] = '{8'h0C, 8'h14, 8'h14, 8'h18, 8'h18, 8'h1C, 8'h04, 8'h08, 8'h10, 8'h1C};
	logic [31:0] cw[10] = '{32'h0000_0258, 32'h0000_0000, 32'h0000_003C, 32'h0000_0005, 32'h0000_012C, 32'h0000_0BB8,
		32'h0000_00FA, 32'h0000_0000, 32'h0000_0064, 32'h0000_0010};
	logic [31:0] ce[10] = '{32'h0000_01F4, 32'h0000_0001, 32'h0000_0032, 32'h0000_000A, 32'h0000_00C8, 32'h0000_07D0,
		32'h0000_00C8, 32'h0000_0001, 32'h0000_0064, 32'h0000_0064};
	mrt_top #(.TICK_CYC(10)) i_dut (.i_mclk(clk), .i_reset_n(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
		.o_hresp(), .i_cmd_speed(cmd), .i_pos_clear_input(pclr), .i_serial_alarm_reset(sreset), .i_home_done(home),
		.i_nv_abs_enable(nv_en), .i_nv_pos_valid(nv_ok), .o_speed_out(spd), .o_damp_gain(damp),
		.o_current_mode(cmode), .o_pos_gain(pgain), .o_spd_gain(sgain), .o_integ_time(itime),
		.o_abs_enable(abs_en), .o_abs_alarm(alarm), .o_pos_valid(valid),
		.o_pos_restore(restore), .o_irq(irq));
	mrt_host i_host (.i_mclk(clk), .o_pos_clear(pclr), .o_home_done(home), .o_serial_reset(sreset));
	initial begin
		forever #10 clk = ~clk;
	end
	// cycle count, hang limit, restore pulse count
	always @(posedge clk) begin
		cyc++;
		if (restore === 1'b1) rcnt++;
		if (cyc == 20000) begin
			err_count++;
			give_verdict();
		end
	end
	task give_verdict;
		$display("comparisons %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one single word transfer: address phase, then data phase
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk) begin
			hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
		end
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0; hwdata <= d; hsel <= 1'b0;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task do_reset(input logic en, input logic ok);
		@(posedge clk) begin
			rst_n <= 1'b0; nv_en <= en; nv_ok <= ok;
		end
		repeat (12) @(posedge clk);
		rcnt = 0;
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
	endtask
	initial begin
		do_reset(1'b1, 1'b0);
		check(32'(alarm), 32'h0000_0001);
		check(32'(valid), 32'h0000_0000);
		check(32'(damp), 32'h0000_002D);
		for (i = 0; i < 6; i++) begin
			xfer(ra[i], 1'b0, 32'h0000_0000);
			check(rd, rv[i]);
		end
		xfer(8'h20, 1'b0, 32'h0000_0000); check(rd, 32'h0000_0001);
		xfer(8'h3C, 1'b0, 32'h0000_0000); check(rd, 32'h0000_0000);
		xfer(8'h24, 1'b0, 32'h0000_0000); check(rd, 32'h0000_0001);
		check(32'(irq), 32'h0000_0000);
		xfer(8'h28, 1'b1, 32'h0000_0003); repeat (2) @(posedge clk); check(32'(irq), 32'h0000_0001);
		xfer(8'h24, 1'b1, 32'h0000_0001); repeat (2) @(posedge clk); check(32'(irq), 32'h0000_0000);
		for (i = 0; i < 10; i++) begin
			xfer(ca[i], 1'b1, cw[i]);
			xfer(ca[i], 1'b0, 32'h0000_0000);
			check(rd, ce[i]);
		end
		xfer(8'h00, 1'b1, 32'h0000_0006); repeat (3) @(posedge clk);
		check(32'(cmode), 32'h0000_0001); check(32'(pgain), 32'h0000_0032);
		check(32'(sgain), 32'h0000_00C8); check(32'(itime), 32'h0000_0064);
		check(32'(abs_en), 32'h0000_0001);
		xfer(8'h00, 1'b1, 32'h0000_0000); repeat (3) @(posedge clk); check(32'(pgain), 32'h0000_0000);
		check(32'(sgain), 32'h0000_0000); check(32'(itime), 32'h0000_0000);
		check(32'(abs_en), 32'h0000_0000);
		i_host.pulse_clear(); repeat (4) @(posedge clk);
		check(32'(alarm), 32'h0000_0000); check(32'(irq), 32'h0000_0001);
		i_host.finish_home(); repeat (3) @(posedge clk); check(32'(valid), 32'h0000_0001);
		xfer(8'h04, 1'b1, 32'h0000_0000); cmd <= 16'sh0064; repeat (40) @(posedge clk);
		check(32'(spd), 32'h0000_0064);
		check(32'(damp), 32'h0000_01F4);
		xfer(8'h00, 1'b1, 32'h0000_0001); xfer(8'h04, 1'b1, 32'h0000_00C8);
		cmd <= 16'sh012C; repeat (40) @(posedge clk); check(32'(spd), 32'h0000_012C);
		// new averaging length keeps the output, then a step is spread over four samples
		xfer(8'h08, 1'b1, 32'h0000_0004); repeat (40) @(posedge clk); check(32'(spd), 32'h0000_012C);
		cmd <= 16'sh01F4; repeat (25) @(posedge clk);
		check(32'(spd > 16'sh012C && spd < 16'sh01F4), 32'h0000_0001);
		repeat (100) @(posedge clk); check(32'(spd), 32'h0000_01F4);
		// slow speed filter on a large step: still accelerating, gain 2 chosen
		xfer(8'h00, 1'b1, 32'h0000_0000); cmd <= 16'sh4000; repeat (40) @(posedge clk);
		check(32'(damp), 32'h0000_0064);
		check(32'(spd < 16'sh4000), 32'h0000_0001);
		do_reset(1'b1, 1'b0);
		check(32'(alarm), 32'h0000_0001);
		i_host.serial_reset(); repeat (4) @(posedge clk); check(32'(alarm), 32'h0000_0000);
		do_reset(1'b1, 1'b1);
		check(32'(alarm), 32'h0000_0000);
		check(32'(rcnt), 32'h0000_0001); check(32'(valid), 32'h0000_0001);
		give_verdict();
	end
endmodule

// ### mrt_top_properties.sv
/*
 checker for the motor response tuning block: bus answer, alarm
 clearing, loop parameter gating and ranges, restore pulse.
 assumes one clock i_mclk and active low async reset i_reset_n.
*/
`timescale 1ns/1ps
module mrt_top_chk (
	input wire i_mclk,
	input wire i_reset_n,
	input wire i_pos_clear_input,
	input wire i_serial_alarm_reset,
	input wire o_hreadyout,
	input wire o_hresp,
	input wire [8:0] o_damp_gain,
	input wire o_current_mode,
	input wire [5:0] o_pos_gain,
	input wire [7:0] o_spd_gain,
	input wire [10:0] o_integ_time,
	input wire o_abs_alarm,
	input wire o_pos_valid,
	input wire o_pos_restore
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	// bus slave never stalls and never errors
	chk_bus_okay: assert property (o_hreadyout && !o_hresp) else $error("bus answer wrong");
	chk_pclr_clear: assert property ($fell(i_pos_clear_input) && o_abs_alarm |-> ##[1:2] !o_abs_alarm)
		else $error("alarm not cleared by falling position clear");
	chk_serial_clear: assert property (i_serial_alarm_reset && o_abs_alarm |-> ##[1:2] !o_abs_alarm)
		else $error("alarm not cleared by serial reset");
	chk_normal_zero: assert property (!o_current_mode |->
		o_pos_gain == 0 && o_spd_gain == 0 && o_integ_time == 0) else $error("loop parameters applied in normal mode");
	chk_loop_range: assert property (o_current_mode |->
		o_pos_gain inside {[1:50]} && o_spd_gain inside {[10:200]} && o_integ_time inside {[100:2000]})
		else $error("loop parameter out of range");
	chk_alarm_invalid: assert property (o_abs_alarm |-> !o_pos_valid) else $error("position valid while alarmed");
	chk_restore_pulse: assert property (o_pos_restore |-> !o_abs_alarm ##1 !o_pos_restore)
		else $error("restore pulse wrong");
	chk_damp_range: assert property (o_damp_gain <= 500) else $error("damping gain out of range");
	cov_alarm_clear: cover property ($fell(o_abs_alarm));
	cov_restore: cover property (o_pos_restore);
	cov_current: cover property ($rose(o_current_mode));
endmodule
bind mrt_top mrt_top_chk i_chk (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_pos_clear_input(i_pos_clear_input),
	.i_serial_alarm_reset(i_serial_alarm_reset), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
	.o_damp_gain(o_damp_gain), .o_current_mode(o_current_mode), .o_pos_gain(o_pos_gain), .o_spd_gain(o_spd_gain),
	.o_integ_time(o_integ_time), .o_abs_alarm(o_abs_alarm), .o_pos_valid(o_pos_valid), .o_pos_restore(o_pos_restore));
